/* bench/tb.sv */
// Self-checking bench of the trigger/timebase router.
// Far card drives the bus lines; backplane and timebase inputs held at idle levels, receive event and fault pulsed once.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tbr_pkg::*;
    typedef struct packed {tbr_cfg_t f; tbr_conn_t c; logic e;} tbr_row_t;
    logic clk_i = 0, resetn_i = 0, req = 0, run = 0, pls = 0, done, err, align, tick;
    tbr_cfg_t cfg = '0;
    tbr_conn_t conn = '0;
    logic [1:0] tst = 0, lcl = 0, strig, started;
    logic [1:0] rx = 2'b00, fn = 2'b11;
    logic tbo;
    logic [6:0] far, lo, oe;
    logic [31:0] cnt;
    tbr_mt_t msel;
    tbr_row_t rows[8];
    int failures = 0, checked = 0, cyc = 0, n;
    tbr_router #(.SLOW_HALF(8)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
        .cfg_i(cfg), .conn_req_i(req), .conn_i(conn), .conn_done_o(done),
        .conn_err_o(err), .task_start_i(tst), .last_clear_i(lcl),
        .trigger_bus_line_i(far), .trigger_bus_line_o(lo),
        .trigger_bus_line_oe_o(oe), .timebase_bus_line_i(1'b0),
        .timebase_bus_line_o(), .timebase_bus_line_oe_o(tbo),
        .star_trig_i(1'b0), .bp_clk10_i(1'b0), .rx_event_i(rx),
        .transceiver_fault_n_i(fn), .start_trig_o(strig),
        .started_o(started), .align_o(align), .tb_tick_o(tick),
        .tb_count_o(cnt), .master_sel_o(msel));
    tbr_far_card far_u (.clk_i(clk_i), .resetn_i(resetn_i), .run_i(run),
        .pulse_i(pls), .line_o(far));
    initial forever #2.5 clk_i = !clk_i;
    task automatic give_verdict();
        if (failures == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic connect(input tbr_cfg_t f, input tbr_conn_t c, input logic e);
        @(posedge clk_i); cfg <= f; conn <= c; req <= 1'b1;
        @(posedge clk_i); req <= 1'b0; #1;
        chk(done === 1'b1 && err === e, "connect answer");
    endtask
    task automatic clr();
        @(posedge clk_i); lcl <= 2'b11;
        @(posedge clk_i); lcl <= 2'b00; #1;
        chk(oe === 7'h00, "routes not released");
    endtask
    function automatic tbr_row_t r(logic g, tbr_ff_t ff, logic i, tbr_src_t s,
                                   tbr_dst_t d, logic [2:0] l, logic e);
        r = '{'{g, ff, 1'b0}, '{i, s, d, l}, e};
    endfunction
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin failures++; give_verdict(); end
    end
    initial begin
        rows = '{r(0, FF_PLAIN, 0, SRC_LINE, DST_START, 2, 0),
                 r(0, FF_PLAIN, 0, SRC_RX_EVT, DST_LINE, 1, 1),
                 r(1, FF_PLAIN, 0, SRC_RX_EVT, DST_LINE, 1, 0),
                 r(0, FF_BACKPLANE, 0, SRC_SLOW, DST_LINE, 6, 1),
                 r(1, FF_CARD_SLOT, 0, SRC_SLOW, DST_LINE, 4, 1),
                 r(1, FF_PLAIN, 0, SRC_STAR, DST_START, 0, 1),
                 r(1, FF_BACKPLANE, 0, SRC_STAR, DST_START, 0, 0),
                 r(1, FF_PLAIN, 0, SRC_XCVR_EVT, DST_LINE, 1, 1)};
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1 chk(msel === MT_LOCAL && cnt === 32'h0, "reset state");
        foreach (rows[k]) begin
            connect(rows[k].f, rows[k].c, rows[k].e);
            clr();
        end
        for (int k = 0; k < 5; k++) connect('0, '{1'b0, SRC_SLOW, DST_LINE, 3'(k)}, k == 4);
        clr();
        for (int k = 0; k < 4; k++) connect(4'h1, '{1'b0, SRC_SLOW, DST_LINE, 3'(k)}, k == 3);
        clr();
        connect(4'h1, '{1'b0, SRC_LINE, DST_RESYNC, 3'h0}, 1'b0);
        connect(4'h1, '{1'b0, SRC_LINE, DST_START, 3'h1}, 1'b0);
        connect(4'h1, '{1'b1, SRC_LINE, DST_START, 3'h2}, 1'b1);
        @(posedge clk_i); run <= 1'b1; tst <= 2'b11;
        @(posedge clk_i); tst <= 2'b00; #1;
        chk(strig === 2'b10 && started === 2'b10, "start fire state");
        n = 0;
        while (align !== 1'b1 && n < 200) begin @(posedge clk_i); #1; n++; end
        chk(align === 1'b1 && cnt === 32'h0, "resync align");
        @(posedge clk_i); pls <= 1'b1;
        @(posedge clk_i); pls <= 1'b0;
        n = 0;
        while (strig[0] !== 1'b1 && n < 40) begin @(posedge clk_i); #1; n++; end
        chk(strig[0] === 1'b1 && started[0] === 1'b1, "routed start");
        repeat (30) @(posedge clk_i);
        pls <= 1'b1;
        @(posedge clk_i); pls <= 1'b0;
        n = 0;
        repeat (40) begin @(posedge clk_i); #1; n += strig[0]; end
        chk(n == 0 && started[0] === 1'b1, "second edge ignored");
        clr();
        n = 0;
        repeat (200) begin @(posedge clk_i); #1; n += align; end
        chk(n == 0, "align without route");
        connect(4'h8, '{1'b0, SRC_LOCAL_TB, DST_TB_LINE, 3'h0}, 1'b0);
        chk(tbo === 1'b1, "export enable");
        connect(4'h8, '{1'b0, SRC_RX_EVT, DST_LINE, 3'h3}, 1'b0);
        connect(4'h8, '{1'b0, SRC_XCVR_EVT, DST_LINE, 3'h4}, 1'b0);
        @(posedge clk_i); rx <= 2'b01; fn <= 2'b10;
        @(posedge clk_i); rx <= 2'b00; fn <= 2'b11; #1;
        chk(lo[4:3] === 2'b01 && oe[4:3] === 2'b11, "events");
        @(posedge clk_i); #1;
        chk(lo[4:3] === 2'b10, "event end");
        give_verdict();
    end
endmodule
`default_nettype wire

/* bench/tbr_far_card.sv */
// Far card on the trigger bus: slow align wave on line 0, start on line 1.
// Runs on the bench clock; pulses are held long enough to be seen.
`timescale 1ns/1ps
`default_nettype none
module tbr_far_card #(
    parameter int unsigned HALF = 40
) (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       run_i,
    input  wire logic       pulse_i,
    output logic      [6:0] line_o
);
    logic [15:0] cnt_reg;
    logic        wave_reg;
    logic [3:0]  hold_reg;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= 16'h0;
            wave_reg <= 1'b0;
            hold_reg <= 4'h0;
        end else begin
            cnt_reg <= (!run_i || cnt_reg == 16'(HALF - 1)) ? 16'h0 : cnt_reg + 16'h1;
            if (!run_i) wave_reg <= 1'b0;
            else if (cnt_reg == 16'(HALF - 1)) wave_reg <= !wave_reg;
            if (pulse_i) hold_reg <= 4'hf;
            else if (hold_reg != 4'h0) hold_reg <= hold_reg - 4'h1;
        end
    end
    assign line_o = {5'h0, hold_reg != 4'h0, wave_reg};
endmodule
`default_nettype wire

/* bench/tbr_router_asserts.sv */
// Checker on the router's connection, start and timebase ports.
// Bound into every router instance; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tbr_router_chk (
    input wire logic             clk_i,
    input wire logic             resetn_i,
    input wire logic             conn_req_i,
    input wire logic             conn_done_o,
    input wire logic             conn_err_o,
    input wire logic [1:0]       start_trig_o,
    input wire logic [1:0]       started_o,
    input wire logic             align_o,
    input wire logic             tb_tick_o,
    input wire logic [31:0]      tb_count_o,
    input wire tbr_pkg::tbr_mt_t master_sel_o
);
    import tbr_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_conn_answer: assert property (conn_req_i |=> conn_done_o)
        else $error("request not answered");
    a_err_with_done: assert property (conn_err_o |-> conn_done_o && $past(conn_req_i))
        else $error("refusal without request");
    a_start_once: assert property (start_trig_o[0] |=> !start_trig_o[0] && started_o[0])
        else $error("start pulse not single");
    a_start_level: assert property ($rose(started_o[0]) |-> start_trig_o[0])
        else $error("started without start pulse");
    a_fired_quiet: assert property (started_o[1] && $past(started_o[1]) |-> !start_trig_o[1])
        else $error("start fired twice");
    a_align_clears: assert property (align_o |-> tb_count_o == 32'h0)
        else $error("align left count nonzero");
    a_count_cause: assert property (!$stable(tb_count_o) |-> tb_tick_o || align_o)
        else $error("count moved without cause");
    a_tick_spacing: assert property (tb_tick_o && master_sel_o == MT_LOCAL
        |=> !tb_tick_o [*5])
        else $error("local ticks too close");
    a_tick_period: assert property (tb_tick_o && master_sel_o == MT_LOCAL
        ##1 !align_o [*4] |=> !tb_tick_o [*4])
        else $error("local tick period short");
endmodule
bind tbr_router tbr_router_chk chk_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .conn_req_i(conn_req_i), .conn_done_o(conn_done_o),
    .conn_err_o(conn_err_o), .start_trig_o(start_trig_o),
    .started_o(started_o), .align_o(align_o), .tb_tick_o(tb_tick_o),
    .tb_count_o(tb_count_o), .master_sel_o(master_sel_o));
`default_nettype wire

/* design/tbr_divider.sv */
// Square-wave generator: toggles every HALF cycles, tick on each rise.
// Synchronous clear restarts the wave low with a full half period.
`timescale 1ns/1ps
`default_nettype none
module tbr_divider #(
    parameter int unsigned HALF = 5
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Restart
    input  wire logic clear_i,
    // Wave and rising tick
    output logic      wave_o,
    output logic      tick_o
);
    initial begin
        if (HALF < 1) $error("tbr_divider: HALF must be at least 1");
    end

    localparam logic [31:0] LAST = 32'(HALF - 1);

    logic [31:0] cnt_reg;
    logic        wave_reg;
    logic        wrap;

    assign wrap   = (cnt_reg == LAST);
    assign tick_o = wrap && !wave_reg && !clear_i;
    assign wave_o = wave_reg;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg  <= 32'h0;
            wave_reg <= 1'b0;
        end else if (clear_i) begin
            cnt_reg  <= 32'h0;
            wave_reg <= 1'b0;
        end else if (wrap) begin
            cnt_reg  <= 32'h0;
            wave_reg <= !wave_reg;
        end else begin
            cnt_reg  <= cnt_reg + 32'h1;
        end
    end
endmodule
`default_nettype wire

/* design/tbr_router.sv */
// Trigger and timebase routing matrix of a two-interface card.
// Assumes one 200 MHz clock; bus lines and backplane inputs are async,
// receive events and transceiver fault come from on-card logic.
`timescale 1ns/1ps
`default_nettype none
module tbr_router #(
    parameter int unsigned SLOW_HALF = tbr_pkg::SLOW_HALF_CYC
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // Card configuration straps
    input  wire tbr_pkg::tbr_cfg_t cfg_i,
    // Connection requests
    input  wire logic              conn_req_i,
    input  wire tbr_pkg::tbr_conn_t conn_i,
    output logic                   conn_done_o,
    output logic                   conn_err_o,
    // Task lifecycle per interface
    input  wire logic [1:0]        task_start_i,
    input  wire logic [1:0]        last_clear_i,
    // General trigger bus lines
    input  wire logic [6:0]        trigger_bus_line_i,
    output logic      [6:0]        trigger_bus_line_o,
    output logic      [6:0]        trigger_bus_line_oe_o,
    // Dedicated timebase line
    input  wire logic              timebase_bus_line_i,
    output logic                   timebase_bus_line_o,
    output logic                   timebase_bus_line_oe_o,
    // Backplane inputs
    input  wire logic              star_trig_i,
    input  wire logic              bp_clk10_i,
    // Controller events per interface
    input  wire logic [1:0]        rx_event_i,
    input  wire logic [1:0]        transceiver_fault_n_i,
    // Sampling side
    output logic      [1:0]        start_trig_o,
    output logic      [1:0]        started_o,
    output logic                   align_o,
    output logic                   tb_tick_o,
    output logic      [31:0]       tb_count_o,
    output tbr_pkg::tbr_mt_t       master_sel_o
);
    import tbr_pkg::*;

    initial begin
        if (SLOW_HALF < 1) $error("tbr_router: SLOW_HALF must be >= 1");
    end

    // Synchronised pin inputs
    logic [N_SYNC-1:0] sy_level;
    logic [N_SYNC-1:0] sy_rise;

    tbr_sync_edge #(.W(N_SYNC)) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .async_i  ({bp_clk10_i, star_trig_i, timebase_bus_line_i,
                    trigger_bus_line_i}),
        .level_o  (),
        .rise_o   (sy_rise)
    );

    // Routing state
    logic        resync_v_reg;
    logic [2:0]  resync_line_reg;
    logic        resync_own_reg;
    tbr_mt_t     master_reg;
    logic        master_own_reg;
    logic        tbexp_v_reg;
    logic        tbexp_own_reg;
    logic [1:0]  start_v_reg;
    tbr_src_t    start_src_reg  [N_IFACE];
    logic [2:0]  start_line_reg [N_IFACE];
    tbr_route_t  route_reg      [N_LINES];
    tbr_st_t     st_reg         [N_IFACE];
    logic [1:0]  fire_reg;
    logic [1:0]  rx_prev_reg;
    logic [6:0]  line_out_reg;
    logic        done_reg;
    logic        err_reg;
    logic [TB_W-1:0] tb_count_reg;
    logic        tb_tick_reg;
    logic        align_reg;

    // Generated clocks
    logic slow_wave;
    logic slow_tick;
    logic local_wave;
    logic local_tick;
    logic align;

    tbr_divider #(.HALF(SLOW_HALF)) u_slow (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .clear_i  (1'b0),
        .wave_o   (slow_wave),
        .tick_o   (slow_tick)
    );

    tbr_divider #(.HALF(LOCAL_HALF_CYC)) u_local (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .clear_i  (align),
        .wave_o   (local_wave),
        .tick_o   (local_tick)
    );

    // Request decode
    wire tbr_src_t   c_src   = conn_i.src;
    wire tbr_dst_t   c_dst   = conn_i.dst;
    wire logic [2:0] c_line  = conn_i.line;
    wire logic       c_if    = conn_i.iface;
    wire logic       g2      = cfg_i.gen2;
    wire logic       bp      = (cfg_i.ff == FF_BACKPLANE);
    wire logic       slot    = (cfg_i.ff == FF_CARD_SLOT);
    wire logic       to_line = (c_dst == DST_LINE);
    wire logic       fr_line = (c_src == SRC_LINE);

    // Line availability per generation and form factor
    wire logic line_ok = (c_line <= LINE_LAST)
        && !(!g2 && bp && c_line == LINE_BP_GONE)
        && !(g2 && slot && c_line >= LINE_SLOT_GONE);

    wire logic pair_g1 =
        (fr_line && (c_dst == DST_RESYNC || c_dst == DST_START))
        || (c_src == SRC_SLOW && (to_line || c_dst == DST_START))
        || (c_src == SRC_START_EVT && to_line);

    wire logic pair_g2 = pair_g1
        || (c_src == SRC_TB_LINE && c_dst == DST_MASTER)
        || (c_src == SRC_STAR && c_dst == DST_START && bp)
        || (c_src == SRC_CLK10 && c_dst == DST_MASTER && bp)
        || (c_src == SRC_LOCAL_TB && c_dst == DST_TB_LINE && !slot)
        || (c_src == SRC_RX_EVT && (to_line || c_dst == DST_START))
        || (c_src == SRC_XCVR_EVT && to_line
            && c_line[0] == c_if);

    wire logic pair_ok = g2 ? pair_g2 : pair_g1;

    // Lines in use per direction
    logic [6:0] in_mask;
    logic [6:0] out_mask;
    always_comb begin
        in_mask  = resync_v_reg ? line_bit(resync_line_reg) : 7'h00;
        out_mask = 7'h00;
        for (int i = 0; i < N_IFACE; i++) begin
            if (start_v_reg[i] && start_src_reg[i] == SRC_LINE) begin
                in_mask = in_mask | line_bit(start_line_reg[i]);
            end
        end
        for (int l = 0; l < N_LINES; l++) begin
            out_mask[l] = route_reg[l].v;
        end
    end

    wire logic [2:0] in_max  = cfg_i.low_speed ? LS_IN_MAX : HS_IN_MAX;
    wire logic [2:0] out_max = cfg_i.low_speed ? LS_OUT_MAX : HS_OUT_MAX;
    wire logic in_full = !g2 && fr_line && !in_mask[c_line]
        && (count7(in_mask) >= in_max);
    wire logic out_full = !g2 && to_line
        && (count7(out_mask) >= out_max);

    logic busy;
    always_comb begin
        case (c_dst)
            DST_LINE:    busy = route_reg[c_line].v;
            DST_TB_LINE: busy = tbexp_v_reg;
            DST_MASTER:  busy = (master_reg != MT_LOCAL);
            DST_RESYNC:  busy = resync_v_reg;
            DST_START:   busy = start_v_reg[c_if];
            default:     busy = 1'b1;
        endcase
    end

    wire logic uses_line = fr_line || to_line;
    wire logic accept = conn_req_i && pair_ok && !busy
        && (!uses_line || line_ok) && !in_full && !out_full;

    // Resync alignment, card wide
    assign align = resync_v_reg && sy_rise[resync_line_reg];

    // Timebase tick source
    wire logic ext_rise = (master_reg == MT_CLK10) ? sy_rise[SY_CLK10]
                                                   : sy_rise[SY_TB];
    wire logic tb_tick = (master_reg == MT_LOCAL) ? local_tick
                                                  : ext_rise;

    // Start trigger source edges per interface
    logic [1:0] rx_rise;
    logic [1:0] src_edge;
    assign rx_rise = rx_event_i & ~rx_prev_reg;
    always_comb begin
        for (int i = 0; i < N_IFACE; i++) begin
            case (start_src_reg[i])
                SRC_LINE:   src_edge[i] = sy_rise[start_line_reg[i]];
                SRC_STAR:   src_edge[i] = sy_rise[SY_STAR];
                SRC_SLOW:   src_edge[i] = slow_tick;
                SRC_RX_EVT: src_edge[i] = rx_rise[i];
                default:    src_edge[i] = 1'b0;
            endcase
        end
    end

    // Start state machine per interface
    tbr_st_t    st_next [N_IFACE];
    logic [1:0] fire;
    always_comb begin
        for (int i = 0; i < N_IFACE; i++) begin
            st_next[i] = st_reg[i];
            fire[i]    = 1'b0;
            case (st_reg[i])
                ST_IDLE: begin
                    if (task_start_i[i] && !start_v_reg[i]) begin
                        st_next[i] = ST_FIRED;
                        fire[i]    = 1'b1;
                    end else if (task_start_i[i]) begin
                        st_next[i] = ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (start_v_reg[i] && src_edge[i]) begin
                        st_next[i] = ST_FIRED;
                        fire[i]    = 1'b1;
                    end
                end
                ST_FIRED: st_next[i] = ST_FIRED;
                default:  st_next[i] = ST_IDLE;
            endcase
            if (last_clear_i[i]) begin
                st_next[i] = ST_IDLE;
                fire[i]    = 1'b0;
            end
        end
    end

    // Line output values
    logic [6:0] line_next;
    always_comb begin
        for (int l = 0; l < N_LINES; l++) begin
            case (route_reg[l].src)
                SRC_SLOW:      line_next[l] = slow_wave;
                SRC_START_EVT: line_next[l] = fire[route_reg[l].iface];
                SRC_RX_EVT:    line_next[l] =
                    rx_event_i[route_reg[l].iface];
                SRC_XCVR_EVT:  line_next[l] =
                    transceiver_fault_n_i[route_reg[l].iface];
                default:       line_next[l] = 1'b0;
            endcase
        end
    end

    // Timebase, start and output registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tb_count_reg <= '0;
            tb_tick_reg  <= 1'b0;
            align_reg    <= 1'b0;
            fire_reg     <= 2'h0;
            rx_prev_reg  <= 2'h0;
            line_out_reg <= 7'h00;
            done_reg     <= 1'b0;
            err_reg      <= 1'b0;
            st_reg[0]    <= ST_IDLE;
            st_reg[1]    <= ST_IDLE;
        end else begin
            if (align) begin
                tb_count_reg <= '0;
            end else if (tb_tick) begin
                tb_count_reg <= tb_count_reg + 32'h1;
            end
            tb_tick_reg  <= tb_tick && !align;
            align_reg    <= align;
            fire_reg     <= fire;
            rx_prev_reg  <= rx_event_i;
            line_out_reg <= line_next;
            done_reg     <= conn_req_i;
            err_reg      <= conn_req_i && !accept;
            st_reg[0]    <= st_next[0];
            st_reg[1]    <= st_next[1];
        end
    end

    // Connection table: connect on accept, release on last clear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            resync_v_reg    <= 1'b0;
            resync_line_reg <= 3'h0;
            resync_own_reg  <= 1'b0;
            master_reg      <= MT_LOCAL;
            master_own_reg  <= 1'b0;
            tbexp_v_reg     <= 1'b0;
            tbexp_own_reg   <= 1'b0;
            start_v_reg     <= 2'h0;
            for (int i = 0; i < N_IFACE; i++) begin
                start_src_reg[i]  <= SRC_LINE;
                start_line_reg[i] <= 3'h0;
            end
            for (int l = 0; l < N_LINES; l++) begin
                route_reg[l] <= '0;
            end
        end else begin
            if (accept) begin
                case (c_dst)
                    DST_RESYNC: begin
                        resync_v_reg    <= 1'b1;
                        resync_line_reg <= c_line;
                        resync_own_reg  <= c_if;
                    end
                    DST_MASTER: begin
                        master_reg     <= (c_src == SRC_CLK10) ? MT_CLK10
                                                               : MT_TB_LINE;
                        master_own_reg <= c_if;
                    end
                    DST_TB_LINE: begin
                        tbexp_v_reg   <= 1'b1;
                        tbexp_own_reg <= c_if;
                    end
                    DST_START: begin
                        start_v_reg[c_if]    <= 1'b1;
                        start_src_reg[c_if]  <= c_src;
                        start_line_reg[c_if] <= c_line;
                    end
                    default: route_reg[c_line] <= {1'b1, c_if, c_src};
                endcase
            end
            for (int i = 0; i < N_IFACE; i++) begin
                if (last_clear_i[i]) begin
                    start_v_reg[i] <= 1'b0;
                    if (resync_v_reg && resync_own_reg == i[0]) begin
                        resync_v_reg <= 1'b0;
                    end
                    if (master_own_reg == i[0]) begin
                        master_reg <= MT_LOCAL;
                    end
                    if (tbexp_own_reg == i[0]) begin
                        tbexp_v_reg <= 1'b0;
                    end
                    for (int l = 0; l < N_LINES; l++) begin
                        if (route_reg[l].iface == i[0]) begin
                            route_reg[l].v <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    // Outputs
    always_comb begin
        for (int l = 0; l < N_LINES; l++) begin
            trigger_bus_line_oe_o[l] = route_reg[l].v;
        end
    end

    assign trigger_bus_line_o     = line_out_reg;
    assign timebase_bus_line_o    = local_wave;
    assign timebase_bus_line_oe_o = tbexp_v_reg;
    assign start_trig_o           = fire_reg;
    assign started_o = {st_reg[1] == ST_FIRED, st_reg[0] == ST_FIRED};
    assign align_o                = align_reg;
    assign tb_tick_o              = tb_tick_reg;
    assign tb_count_o             = tb_count_reg;
    assign master_sel_o           = master_reg;
    assign conn_done_o            = done_reg;
    assign conn_err_o             = err_reg;

endmodule
`default_nettype wire

/* design/tbr_sync_edge.sv */
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Inputs arrive from pins outside the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module tbr_sync_edge #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // Asynchronous inputs
    input  wire logic [W-1:0] async_i,
    // Filtered level and rising edge
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] rise_o
);
    initial begin
        if (W < 1) $error("tbr_sync_edge: W must be at least 1");
    end

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;
    logic [W-1:0] agree;
    logic [W-1:0] level_next;

    // A change counts once stages two and three agree
    assign agree      = ~(s2_reg ^ s3_reg);
    assign level_next = (agree & s3_reg) | (~agree & level_reg);
    assign rise_o     = level_next & ~level_reg;
    assign level_o    = level_reg;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            level_reg <= '0;
        end else begin
            s1_reg    <= async_i;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
        end
    end
endmodule
`default_nettype wire

/* shared/tbr_pkg.sv */
// Shared constants, types and helpers of the trigger/timebase router.
// Assumes a single 200 MHz core clock.
package tbr_pkg;

    // Clock and derived timing counts
    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned SLOW_ALIGN_HZ  = 10;
    localparam int unsigned LOCAL_TB_HZ    = 20_000_000;
    localparam int unsigned SLOW_HALF_CYC  = CLK_HZ / (2 * SLOW_ALIGN_HZ);
    localparam int unsigned LOCAL_HALF_CYC = CLK_HZ / (2 * LOCAL_TB_HZ);

    // Sizes and positions
    localparam int unsigned N_LINES  = 7;
    localparam int unsigned N_IFACE  = 2;
    localparam int unsigned N_SYNC   = 10;
    localparam int unsigned SY_TB    = 7;
    localparam int unsigned SY_STAR  = 8;
    localparam int unsigned SY_CLK10 = 9;
    localparam int unsigned TB_W     = 32;
    localparam logic [2:0]  LINE_LAST      = 3'h6;
    localparam logic [2:0]  LINE_BP_GONE   = 3'h6;
    localparam logic [2:0]  LINE_SLOT_GONE = 3'h4;

    // Per-direction line limits of first generation cards
    localparam logic [2:0] HS_IN_MAX  = 3'h4;
    localparam logic [2:0] HS_OUT_MAX = 3'h4;
    localparam logic [2:0] LS_IN_MAX  = 3'h2;
    localparam logic [2:0] LS_OUT_MAX = 3'h3;

    typedef enum logic [3:0] {
        SRC_LINE      = 4'h0,
        SRC_TB_LINE   = 4'h1,
        SRC_STAR      = 4'h2,
        SRC_CLK10     = 4'h3,
        SRC_LOCAL_TB  = 4'h4,
        SRC_SLOW      = 4'h5,
        SRC_RX_EVT    = 4'h6,
        SRC_XCVR_EVT  = 4'h7,
        SRC_START_EVT = 4'h8
    } tbr_src_t;

    typedef enum logic [2:0] {
        DST_LINE    = 3'h0,
        DST_TB_LINE = 3'h1,
        DST_MASTER  = 3'h2,
        DST_RESYNC  = 3'h3,
        DST_START   = 3'h4
    } tbr_dst_t;

    typedef enum logic [1:0] {
        FF_PLAIN     = 2'h0,
        FF_BACKPLANE = 2'h1,
        FF_CARD_SLOT = 2'h2
    } tbr_ff_t;

    typedef enum logic [1:0] {
        MT_LOCAL   = 2'h0,
        MT_TB_LINE = 2'h1,
        MT_CLK10   = 2'h2
    } tbr_mt_t;

    // Gray codes along idle, armed, fired
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_FIRED = 2'b11
    } tbr_st_t;

    typedef struct packed {
        logic    gen2;
        tbr_ff_t ff;
        logic    low_speed;
    } tbr_cfg_t;

    typedef struct packed {
        logic       iface;
        tbr_src_t   src;
        tbr_dst_t   dst;
        logic [2:0] line;
    } tbr_conn_t;

    typedef struct packed {
        logic     v;
        logic     iface;
        tbr_src_t src;
    } tbr_route_t;

    function automatic logic [6:0] line_bit(input logic [2:0] l);
        line_bit = 7'h01 << l;
    endfunction

    function automatic logic [2:0] count7(input logic [6:0] m);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < 7; i++) begin
            c = c + {2'h0, m[i]};
        end
        count7 = c;
    endfunction

endpackage
